// ===== dcsp_regs.vh
// Constants for the daisy-chain shift port
`ifndef DCSP_REGS_VH
`define DCSP_REGS_VH
`define DCSP_WORD_BITS   16
`define DCSP_CNT_BITS    5
`define DCSP_FIFO_DEPTH  16
`define DCSP_FIFO_ABITS  4
`endif

// ===== dcsp_top.v
// Daisy-chain serial input port with word FIFO
`timescale 1ns/1ps
`include "dcsp_regs.vh"

// ---------------------------------------------------------------
// Word FIFO
// ---------------------------------------------------------------
module dcsp_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter ABITS = 4
) (
  input  wire             ref_clk,
  input  wire             sys_rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ABITS:0]   wr_ptr_r;
  reg [ABITS:0]   rd_ptr_r;
  wire            full;
  wire            empty;
  // Extra pointer bit tells a full ring from an empty one
  assign full  = (wr_ptr_r[ABITS] != rd_ptr_r[ABITS]) &&
                 (wr_ptr_r[ABITS-1:0] == rd_ptr_r[ABITS-1:0]);
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_r[ABITS-1:0]];
  always @(posedge ref_clk) begin
    if (in_valid && !full)
      mem[wr_ptr_r[ABITS-1:0]] <= in_data;
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr_r <= {(ABITS+1){1'b0}};
      rd_ptr_r <= {(ABITS+1){1'b0}};
    end else begin
      if (in_valid && !full)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (out_ready && !empty)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule // dcsp_fifo

// ---------------------------------------------------------------
// Shift port
// ---------------------------------------------------------------
module dcsp_top (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        shift_clock,
  input  wire        frame_select_n,
  input  wire        serial_data_in,
  input  wire        chain_enable_pin,
  input  wire        load_output_registers,
  output reg         chain_data_out,
  output reg  [15:0] output_word,
  output reg         output_word_valid,
  output reg         word_overflow,
  output reg         shift_stalled
);
  reg  [2:0]  sclk_sync_r;
  reg  [1:0]  fsn_sync_r;
  reg  [1:0]  din_sync_r;
  reg  [1:0]  chain_enable_pin_sync_r;
  reg  [2:0]  load_output_registers_sync_r;
  reg         fsn_d_r;
  reg  [15:0] shift_r;
  reg  [4:0]  count_r;
  reg  [15:0] in_word_r;
  reg         push_r;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        fsn;
  wire        frame_end;
  wire        ld_rise;
  wire        chained;
  wire        take_bit;
  wire        word_full;
  wire        fifo_in_ready;
  wire [15:0] fifo_out_data;
  wire        fifo_out_valid;
  wire        fifo_pop;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Link clock only sampled; 160 ns period leaves 4 ref_clk per half
  // Idle reset levels keep a false edge from following reset
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      sclk_sync_r <= 3'h0;
      fsn_sync_r  <= 2'h3;
      din_sync_r  <= 2'h0;
      chain_enable_pin_sync_r <= 2'h0;
      load_output_registers_sync_r <= 3'h7;
      fsn_d_r     <= 1'b1;
    end else begin
      sclk_sync_r <= {sclk_sync_r[1:0], shift_clock};
      fsn_sync_r  <= {fsn_sync_r[0], frame_select_n};
      din_sync_r  <= {din_sync_r[0], serial_data_in};
      chain_enable_pin_sync_r <= {chain_enable_pin_sync_r[0], chain_enable_pin};
      load_output_registers_sync_r <= {load_output_registers_sync_r[1:0], load_output_registers};
      fsn_d_r     <= fsn_sync_r[1];
    end
  end

  assign sclk_rise = sclk_sync_r[1] && !sclk_sync_r[2];
  assign sclk_fall = !sclk_sync_r[1] && sclk_sync_r[2];
  assign fsn       = fsn_sync_r[1];
  assign frame_end = fsn && !fsn_d_r;
  assign ld_rise   = load_output_registers_sync_r[1] && !load_output_registers_sync_r[2];
  assign chained   = chain_enable_pin_sync_r[1];
  // Count saturates at sixteen, so a long standalone frame never wraps
  assign word_full = count_r[4];
  // Gating only in standalone; chained lets every in-frame clock through
  assign take_bit  = sclk_rise && !fsn &&
                     (chained || !word_full);

  // ---------------------------------------------------------------
  // Shift register and chain output
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      shift_r        <= 16'h0000;
      count_r        <= 5'h00;
      chain_data_out <= 1'b0;
    end else begin
      if (take_bit) begin
        shift_r <= {shift_r[14:0], din_sync_r[1]};
        if (!word_full)
          count_r <= count_r + 5'h01;
      end
      if (frame_end)
        count_r <= 5'h00;
      // Oldest bit after fall; holds a full period so both edges see it
      if (!chained)
        chain_data_out <= 1'b0;
      else if (sclk_fall && !fsn)
        chain_data_out <= shift_r[15];
    end
  end

  // ---------------------------------------------------------------
  // Frame update and FIFO feed
  // ---------------------------------------------------------------
  // Update needs a full word; short frames are dropped
  // Lost word stays flagged until reset; nothing else clears it
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      in_word_r     <= 16'h0000;
      push_r        <= 1'b0;
      word_overflow <= 1'b0;
      shift_stalled <= 1'b0;
    end else begin
      push_r        <= 1'b0;
      shift_stalled <= !fifo_in_ready;
      if (frame_end && word_full) begin
        in_word_r <= shift_r;
        if (fifo_in_ready)
          push_r <= 1'b1;
        else
          word_overflow <= 1'b1;
      end
    end
  end

  dcsp_fifo #(
    .WIDTH (`DCSP_WORD_BITS),
    .DEPTH (`DCSP_FIFO_DEPTH),
    .ABITS (`DCSP_FIFO_ABITS)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_data   (in_word_r),
    .in_valid  (push_r),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  // ---------------------------------------------------------------
  // Output register load
  // ---------------------------------------------------------------
  // One queued word moves per load strobe, so all chained parts align
  assign fifo_pop = ld_rise && fifo_out_valid;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      output_word       <= 16'h0000;
      output_word_valid <= 1'b0;
    end else begin
      output_word_valid <= 1'b0;
      if (fifo_pop) begin
        output_word       <= fifo_out_data;
        output_word_valid <= 1'b1;
      end
    end
  end
endmodule // dcsp_top

// ===== dcsp_props_properties.sv
// Port checker for the shift port
`timescale 1ns/1ps
module dcsp_props (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        shift_clock,
  input wire        frame_select_n,
  input wire        serial_data_in,
  input wire        chain_enable_pin,
  input wire        load_output_registers,
  input wire        chain_data_out,
  input wire [15:0] output_word,
  input wire        output_word_valid,
  input wire        word_overflow,
  input wire        shift_stalled
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  valid_one_pulse_a: assert property (
    output_word_valid |=> !output_word_valid) else $error("long valid");
  word_hold_a: assert property (
    !output_word_valid |-> $stable(output_word)) else $error("word moved");
  load_cause_a: assert property (
    output_word_valid |-> $past(load_output_registers, 3) &&
      !$past(load_output_registers, 4)) else $error("no strobe");
  alone_zero_a: assert property (
    (!chain_enable_pin)[*8] |-> !chain_data_out) else $error("chain out");
  // Four high samples rule out a recent synced falling edge
  out_hold_a: assert property (
    (shift_clock && chain_enable_pin)[*4] |-> $stable(chain_data_out))
    else $error("chain out moved on high clock");
  idle_hold_a: assert property (
    (frame_select_n && chain_enable_pin)[*8] |-> $stable(chain_data_out))
    else $error("chain out moved outside frame");
  overflow_sticky_a: assert property (
    word_overflow |=> word_overflow) else $error("overflow cleared");
  overflow_cause_a: assert property (
    $rose(word_overflow) |-> $past(shift_stalled)) else $error("overflow");
endmodule // dcsp_props
bind dcsp_top dcsp_props dcsp_props_inst (.ref_clk, .sys_rst, .shift_clock,
  .frame_select_n, .serial_data_in, .chain_enable_pin,
  .load_output_registers, .chain_data_out, .output_word,
  .output_word_valid, .word_overflow, .shift_stalled);

// ===== dcsp_host.sv
// Host model driving the serial frame pins
`timescale 1ns/1ps
module dcsp_host (
  input wire ref_clk,
  input wire chain_data_out,
  output reg shift_clock,
  output reg frame_select_n,
  output reg serial_data_in
);
  integer i;
  reg [31:0] rise_seen_r;
  reg [31:0] fall_seen_r;
  // Next device in the chain samples on both link edges
  always @(posedge shift_clock) begin
    rise_seen_r <= {rise_seen_r[30:0], chain_data_out};
  end
  always @(negedge shift_clock) begin
    fall_seen_r <= {fall_seen_r[30:0], chain_data_out};
  end
  initial begin
    shift_clock = 1'b0;
    frame_select_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // Clock stands low between frames; burst of exact length
  task xfer(input [31:0] b, input integer n);
    begin
      @(negedge ref_clk);
      frame_select_n = 1'b0;
      for (i = n - 1; i >= 0; i = i - 1) begin
        serial_data_in = b[i];
        repeat (4) @(negedge ref_clk);
        shift_clock = 1'b1;
        repeat (4) @(negedge ref_clk);
        shift_clock = 1'b0;
      end
      repeat (4) @(negedge ref_clk);
      frame_select_n = 1'b1;
      serial_data_in = ~serial_data_in;
      repeat (8) @(negedge ref_clk);
    end
  endtask
  // Free-running clock with the frame closed must shift nothing
  task stray(input integer n);
    begin
      serial_data_in = 1'b1;
      for (i = 0; i < n; i = i + 1) begin
        repeat (4) @(negedge ref_clk);
        shift_clock = 1'b1;
        repeat (4) @(negedge ref_clk);
        shift_clock = 1'b0;
      end
      repeat (8) @(negedge ref_clk);
    end
  endtask
endmodule // dcsp_host

// ===== test_dcsp_top.sv
// Self-checking bench for the shift port
`timescale 1ns/1ps
module test_dcsp_top;
  reg         ref_clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         chain_enable_pin = 1'b0;
  reg         load_output_registers = 1'b0;
  wire        shift_clock, frame_select_n, serial_data_in, chain_data_out;
  wire [15:0] output_word;
  wire        output_word_valid, word_overflow, shift_stalled;
  integer     mismatches = 0;
  integer     num_checks = 0;
  integer     k;
  reg         seen;
  always #10 ref_clk = ~ref_clk;
  dcsp_top dcsp_top_inst (.ref_clk, .sys_rst, .shift_clock, .frame_select_n,
    .serial_data_in, .chain_enable_pin, .load_output_registers,
    .chain_data_out, .output_word, .output_word_valid, .word_overflow,
    .shift_stalled);
  dcsp_host dcsp_host_inst (.ref_clk, .chain_data_out, .shift_clock,
    .frame_select_n, .serial_data_in);
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0t %h %h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      if (mismatches == 0 && num_checks > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  // Strobe held long enough to cover the synchroniser delay
  task ld(input want, input [15:0] exp);
    begin
      seen = 1'b0;
      load_output_registers = 1'b1;
      repeat (12) begin
        @(negedge ref_clk);
        if (output_word_valid === 1'b1) seen = 1'b1;
      end
      load_output_registers = 1'b0;
      chk(seen, want);
      chk(output_word, exp);
      repeat (6) @(negedge ref_clk);
    end
  endtask
  task t_alone;
    begin
      dcsp_host_inst.xfer(32'h000A5C3F, 20);
      chk(chain_data_out, 16'h0000);
      ld(1'b1, 16'hA5C3);
    end
  endtask
  task t_short;
    begin
      dcsp_host_inst.xfer(32'h0000005A, 8);
      dcsp_host_inst.stray(8);
      ld(1'b0, 16'hA5C3);
    end
  endtask
  task t_chain;
    begin
      chain_enable_pin = 1'b1;
      repeat (8) @(negedge ref_clk);
      dcsp_host_inst.xfer(32'h1234BEEF, 32);
      chk(chain_data_out, 16'h0001);
      chk(dcsp_host_inst.rise_seen_r[31:16], 16'h435A);
      chk(dcsp_host_inst.rise_seen_r[15:0], 16'h1234);
      chk(dcsp_host_inst.fall_seen_r[31:16], 16'h435A);
      chk(dcsp_host_inst.fall_seen_r[15:0], 16'h1234);
      ld(1'b1, 16'hBEEF);
    end
  endtask
  task t_full;
    begin
      for (k = 0; k < 17; k = k + 1) dcsp_host_inst.xfer(32'hC000 + k, 16);
      chk(word_overflow, 16'h0001);
      chk(shift_stalled, 16'h0001);
      for (k = 0; k < 16; k = k + 1) ld(1'b1, 16'hC000 + k);
      chk(shift_stalled, 16'h0000);
      chk(word_overflow, 16'h0001);
    end
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_alone;
    t_short;
    t_chain;
    t_full;
    close_out;
  end
  initial begin
    #400000;
    mismatches = mismatches + 1;
    close_out;
  end
endmodule // test_dcsp_top
